// ---- hdl/svmc_pkg.sv ----
// package: register map and field layout of the supply monitor control block
package svmc_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] SVMC_ADDR_WIDTH_DUMMY = 4'h0;
    localparam logic [3:0] POWER_CONTROL_REG_OFS      = 4'h0;
    localparam logic [3:0] POWER_CONTROL_REG_TWO_OFS  = 4'h1;
    localparam logic [3:0] COMPARATOR_CONTROL_REG_OFS = 4'h2;
    localparam logic [3:0] LEVEL_SELECT_REG_OFS       = 4'h3;
    localparam logic [3:0] IRQ_STATUS_REG_OFS         = 4'h4;
    localparam logic [3:0] IRQ_ENABLE_REG_OFS         = 4'h5;

    // power_control_reg fields
    localparam int COMPARATOR_ENABLE_BIT = 2;
    localparam int DETECTOR_ENABLE_BIT   = 5;
    // power_control_reg_two fields
    localparam int DETECTOR_STATUS_BIT   = 6;
    // level select register fields
    localparam int BIAS_RANGE_LOW_BIT    = 4;
    localparam int BIAS_RANGE_HIGH_BIT   = 5;
    // irq status / enable fields
    localparam int LOW_VOLT_FLAG_BIT     = 0;
    localparam int CMP_CHANGE_FLAG_BIT   = 1;
    localparam int LOW_VOLT_IE_BIT       = 0;
    localparam int GLOBAL_IE_BIT         = 1;

    // source select encodings
    localparam logic [1:0] NONINV_PIN_B1   = 2'h0;
    localparam logic [1:0] NONINV_PIN_B4   = 2'h1;
    localparam logic [1:0] NONINV_DIVIDER  = 2'h2;
    localparam logic [1:0] INV_PIN_B2      = 2'h0;
    localparam logic [1:0] INV_PIN_B5      = 2'h1;
    localparam logic [1:0] INV_BANDGAP     = 2'h2;
    localparam logic [1:0] INV_DIVIDER     = 2'h3;

    // reset values
    localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
    localparam logic [7:0] CMP_CONTROL_RST   = 8'h00;
    localparam logic [7:0] LEVEL_SELECT_RST  = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RST    = 8'h00;

    // unlisted detector level codes
    localparam logic [3:0] LEVEL_CODE_NONE_A = 4'h0;
    localparam logic [3:0] LEVEL_CODE_NONE_B = 4'h9;
endpackage

// ---- hdl/svmc_ctrl.sv ----
// supply voltage monitor control: registers, comparator sync, detector and irq flags
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps

module svmc_ctrl #(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rstn_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [7:0]        reg_rdata_out,
    input  wire logic              halt_mode_in,
    input  wire logic              cmp_raw_in,
    output logic                   comparator_enable_out,
    output logic                   detector_enable_out,
    output logic      [1:0]        noninv_source_select_out,
    output logic      [1:0]        inv_source_select_out,
    output logic                   bias_range_high_out,
    output logic                   bias_range_low_out,
    output logic      [3:0]        level_select_out,
    output logic                   level_valid_out,
    output logic                   monitor_mode_out,
    output logic                   irq_request_out
);
    import svmc_pkg::*;

    logic [7:0] power_control_q;
    logic [7:0] cmp_control_q;
    logic [7:0] level_select_q;
    logic [7:0] irq_enable_q;
    logic       cmp_meta_q;
    logic       cmp_sync_q;
    logic       cmp_prev_q;
    logic       low_volt_irq_flag_q;
    logic       cmp_change_flag_q;
    logic [7:0] rdata_q;
    logic       cmp_active;
    logic       detector_level;
    logic       lv_event;
    logic       cmp_event;
    logic       wr_status;
    logic [7:0] rd_mux;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // software-writable control registers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            power_control_q <= POWER_CONTROL_RST;
            cmp_control_q   <= CMP_CONTROL_RST;
            level_select_q  <= LEVEL_SELECT_RST;
            irq_enable_q    <= IRQ_ENABLE_RST;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, POWER_CONTROL_REG_OFS)) begin
                power_control_q <= reg_wdata_in;
            end
            if (hit(reg_addr_in, COMPARATOR_CONTROL_REG_OFS)) begin
                cmp_control_q <= {4'h0, reg_wdata_in[3:0]};
            end
            if (hit(reg_addr_in, LEVEL_SELECT_REG_OFS)) begin
                level_select_q <= {2'h0, reg_wdata_in[5:0]};
            end
            if (hit(reg_addr_in, IRQ_ENABLE_REG_OFS)) begin
                irq_enable_q <= {6'h00, reg_wdata_in[1:0]};
            end
        end
    end

    // halt overrides software enable
    assign cmp_active = power_control_q[COMPARATOR_ENABLE_BIT] & ~halt_mode_in;

    assign comparator_enable_out    = cmp_active;
    assign detector_enable_out      = power_control_q[DETECTOR_ENABLE_BIT];
    assign noninv_source_select_out = cmp_control_q[3:2];
    assign inv_source_select_out    = cmp_control_q[1:0];
    assign bias_range_high_out      = level_select_q[BIAS_RANGE_HIGH_BIT];
    assign bias_range_low_out       = level_select_q[BIAS_RANGE_LOW_BIT];
    assign level_select_out         = level_select_q[3:0];
    // unlisted codes still drive the divider; only flagged on level_valid_out, which no register reads back
    assign level_valid_out = (level_select_q[3:0] != LEVEL_CODE_NONE_A) &&
                             (level_select_q[3:0] != LEVEL_CODE_NONE_B);
    // divider on plus, bandgap on minus: result 1 above threshold, 0 below
    assign monitor_mode_out = (cmp_control_q[3:2] == NONINV_DIVIDER) &&
                              (cmp_control_q[1:0] == INV_BANDGAP);

    // analog result is asynchronous; first flop feeds only the second
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_raw_in;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // detector output follows result while detector and comparator are both on; idles high so no false drop
    assign detector_level = (power_control_q[DETECTOR_ENABLE_BIT] && cmp_active) ?
                            cmp_sync_q : 1'b1;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmp_prev_q <= 1'b1;
        end else begin
            cmp_prev_q <= detector_level;
        end
    end

    assign lv_event  = cmp_prev_q & ~detector_level;
    assign cmp_event = cmp_prev_q ^ detector_level;
    assign wr_status = reg_wr_in & hit(reg_addr_in, IRQ_STATUS_REG_OFS);

    // sticky flags: set beats a same-cycle software clear
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_volt_irq_flag_q <= 1'b0;
        end else if (lv_event && irq_enable_q[LOW_VOLT_IE_BIT]) begin
            low_volt_irq_flag_q <= 1'b1;
        end else if (wr_status && !reg_wdata_in[LOW_VOLT_FLAG_BIT]) begin
            low_volt_irq_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmp_change_flag_q <= 1'b0;
        end else if (cmp_event) begin
            cmp_change_flag_q <= 1'b1;
        end else if (wr_status && !reg_wdata_in[CMP_CHANGE_FLAG_BIT]) begin
            cmp_change_flag_q <= 1'b0;
        end
    end

    // both enables needed before the cpu is diverted
    assign irq_request_out = (low_volt_irq_flag_q | cmp_change_flag_q) &
                             irq_enable_q[LOW_VOLT_IE_BIT] &
                             irq_enable_q[GLOBAL_IE_BIT];

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr_in)
            ADDR_W'(POWER_CONTROL_REG_OFS):      rd_mux = power_control_q;
            ADDR_W'(POWER_CONTROL_REG_TWO_OFS): begin
                rd_mux[DETECTOR_STATUS_BIT] = detector_level;
            end
            ADDR_W'(COMPARATOR_CONTROL_REG_OFS): rd_mux = cmp_control_q;
            ADDR_W'(LEVEL_SELECT_REG_OFS):       rd_mux = level_select_q;
            ADDR_W'(IRQ_STATUS_REG_OFS): begin
                rd_mux[LOW_VOLT_FLAG_BIT]   = low_volt_irq_flag_q;
                rd_mux[CMP_CHANGE_FLAG_BIT] = cmp_change_flag_q;
            end
            ADDR_W'(IRQ_ENABLE_REG_OFS):         rd_mux = irq_enable_q;
            default:                             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_q;
endmodule

// ---- tb/svmc_ctrl_assertions.sv ----
// port-level checks for the supply monitor control block
`timescale 1ns/1ps
module svmc_ctrl_checker #(parameter int ADDR_W = 4) (
    input wire logic              clk_sys_in,
    input wire logic              rstn_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0]        reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic              halt_mode_in,
    input wire logic              comparator_enable_out,
    input wire logic              detector_enable_out,
    input wire logic [1:0]        noninv_source_select_out,
    input wire logic [1:0]        inv_source_select_out,
    input wire logic [3:0]        level_select_out,
    input wire logic              level_valid_out,
    input wire logic              monitor_mode_out,
    input wire logic              irq_request_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    property p_halt; halt_mode_in |-> !comparator_enable_out; endproperty
    a_halt: assert property (p_halt) else $error("comparator on in halt");
    // idle detector reads high, once the sync chain has flushed
    property p_idle; reg_rd_in && reg_addr_in == 4'h1 && !detector_enable_out
        && !$past(detector_enable_out) && $past(rstn_in, 3) |=> reg_rdata_out == 8'h40; endproperty
    a_idle: assert property (p_idle) else $error("idle detector status wrong");
    property p_lvl; level_valid_out == !(level_select_out inside {4'h0, 4'h9}); endproperty
    a_lvl: assert property (p_lvl) else $error("level valid wrong");
    property p_mon; monitor_mode_out ==
        ({noninv_source_select_out, inv_source_select_out} == 4'hA); endproperty
    a_mon: assert property (p_mon) else $error("monitor mode wrong");
    property p_src; reg_wr_in && reg_addr_in == 4'h2 |=>
        {noninv_source_select_out, inv_source_select_out} == $past(reg_wdata_in[3:0]); endproperty
    a_src: assert property (p_src) else $error("source select wrong");
    property p_pwr; reg_wr_in && reg_addr_in == 4'h0 |=> detector_enable_out ==
        $past(reg_wdata_in[5]) && comparator_enable_out == ($past(reg_wdata_in[2]) && !halt_mode_in);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power control wrong");
    property p_hold; !$past(reg_wr_in) |-> $stable({detector_enable_out, level_select_out,
        noninv_source_select_out, inv_source_select_out}); endproperty
    a_hold: assert property (p_hold) else $error("setting moved without write");
    property p_irq; $fell(irq_request_out) |-> $past(reg_wr_in); endproperty
    a_irq: assert property (p_irq) else $error("irq dropped without write");
endmodule
bind svmc_ctrl svmc_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- tb/supply_voltage_monitor_ctrl_test.sv ----
// self-checking bench for the supply monitor control block
`timescale 1ns/1ps
module supply_voltage_monitor_ctrl_test;
    import svmc_pkg::*;
    logic       clk_sys_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0, halt_mode_in = 0;
    logic       cmp_raw_in = 1, prev_lvl = 1, lf = 0, cf = 0;
    logic [3:0] reg_addr_in = 4'h0, level_select_out;
    logic [7:0] reg_wdata_in = 8'h00, rd_q, reg_rdata_out, seed_q = 8'h3C;
    logic [1:0] noninv_source_select_out, inv_source_select_out;
    logic       comparator_enable_out, detector_enable_out, bias_range_high_out;
    logic       bias_range_low_out, level_valid_out, monitor_mode_out, irq_request_out;
    int         mismatches = 0, samples_checked = 0;
    svmc_ctrl dut (.*);
    initial forever #10 clk_sys_in = ~clk_sys_in;
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 rd_q = reg_rdata_out;
    endtask
    task automatic final_report();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        mismatches++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        // unmapped places read zero too
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk(rd_q, (a == 1) ? 8'h40 : 8'h00);
        end
        for (int c = 0; c < 16; c++) begin
            seed_q = nxt(seed_q);
            wr(LEVEL_SELECT_REG_OFS, {2'b00, seed_q[1:0], c[3:0]});
            chk({1'b0, level_valid_out, bias_range_high_out, bias_range_low_out, level_select_out},
                {1'b0, !(c == 0 || c == 9), seed_q[1:0], c[3:0]});
        end
        wr(LEVEL_SELECT_REG_OFS, 8'h08);
        wr(COMPARATOR_CONTROL_REG_OFS, 8'h0A);
        chk({3'h0, monitor_mode_out, noninv_source_select_out, inv_source_select_out}, 8'h1A);
        wr(POWER_CONTROL_REG_OFS, 8'h24);
        chk({6'h00, detector_enable_out, comparator_enable_out}, 8'h03);
        wr(IRQ_ENABLE_REG_OFS, 8'h03);
        // settle after a level change before status is trusted
        repeat (50) @(posedge clk_sys_in);
        wr(IRQ_STATUS_REG_OFS, 8'h00);
        for (int i = 0; i < 24; i++) begin
            seed_q = nxt(seed_q);
            @(posedge clk_sys_in);
            cmp_raw_in <= seed_q[0];
            cf = cf | (seed_q[0] != prev_lvl);
            lf = lf | (prev_lvl && !seed_q[0]);
            prev_lvl = seed_q[0];
            repeat (4) @(posedge clk_sys_in);
            rd(POWER_CONTROL_REG_TWO_OFS);
            chk(rd_q, {1'b0, seed_q[0], 6'h00});
            chk({7'h00, irq_request_out}, {7'h00, cf | lf});
            rd(IRQ_STATUS_REG_OFS);
            chk(rd_q, {6'h00, cf, lf});
            // a one written leaves its flag standing
            wr(IRQ_STATUS_REG_OFS, {6'h00, seed_q[3:2]});
            cf = cf & seed_q[3];
            lf = lf & seed_q[2];
        end
        wr(IRQ_STATUS_REG_OFS, 8'h00);
        wr(IRQ_ENABLE_REG_OFS, 8'h01);
        @(posedge clk_sys_in);
        cmp_raw_in <= !prev_lvl;
        repeat (5) @(posedge clk_sys_in);
        chk({7'h00, irq_request_out}, 8'h00);
        wr(IRQ_ENABLE_REG_OFS, 8'h03);
        chk({7'h00, irq_request_out}, 8'h01);
        wr(LEVEL_SELECT_REG_OFS, 8'h08);
        @(posedge clk_sys_in);
        halt_mode_in <= 1'b1;
        #1 chk({7'h00, comparator_enable_out}, 8'h00);
        repeat (4) @(posedge clk_sys_in);
        rd(POWER_CONTROL_REG_TWO_OFS);
        chk(rd_q, 8'h40);
        final_report();
    end
endmodule
